// ==== tb/fcel_core_model.sv ====
/*
  Pipeline and bus side model: raises one fault event with its address.
  Assumes the caller steps on mclk; one event per call.
*/
`timescale 1ns/1ps
module fcel_core_model (
  // Clock
  input wire logic mclk,
  // Events, address, return code
  output logic [16:0] ev,
  output logic [31:0] busfault_addr_reg,
  output logic [31:0] retCode
);
  initial begin
    ev = 17'h00000;
    busfault_addr_reg = 32'h0;
    retCode = 32'h0;
  end
  // Single-cycle pulse; address is not held afterwards
  task automatic fire(input int i, input logic [31:0] a);
    @(posedge mclk);
    ev[i] <= 1'b1;
    busfault_addr_reg <= a;
    retCode <= a;
    @(posedge mclk);
    ev <= 17'h00000;
    busfault_addr_reg <= ~a;
    retCode <= ~a;
  endtask : fire
endmodule : fcel_core_model

// ==== tb/fcel_fault_props.sv ====
/*
  Concurrent checks on the fault unit's ports.
  Assumes one clock domain, mclk, with nrst as a synchronous active-low reset.
*/
`timescale 1ns/1ps
module fcel_fault_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Events and context
  input wire logic vectorReadErr,
  input wire logic busPushErr,
  input wire logic preciseDataErr,
  input wire logic zeroDivisor,
  input wire logic retCodeLoad,
  input wire logic [31:0] retCode,
  input wire logic busHandlerEntry,
  input wire fcel_pkg::fcel_ctx_t curContext,
  input wire logic nmiEvent,
  input wire logic debugHalt,
  // Outputs
  input wire logic [2:0] takeClass,
  input wire logic takeHard,
  input wire logic lockedUp,
  input wire logic lockedFromNmi,
  input wire logic retCodeValid,
  input wire logic [1:0] retTarget
);
  import fcel_pkg::*;
  logic freeRun;
  // Lockup paths suppress the take pulses
  assign freeRun = !lockedUp && curContext == FCEL_CTX_OTHER;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence sLockedNmi;
    lockedUp && lockedFromNmi;
  endsequence
  sequence sNmiOnly;
    nmiEvent && !debugHalt;
  endsequence
  AST_VECTOR_READ_FLAG_HARD: assert property (vectorReadErr && freeRun |=> takeHard)
    else $error("vector read error took no hard fault");
  AST_LOCK_ENTRY: assert property (vectorReadErr && curContext != FCEL_CTX_OTHER |=> lockedUp && !takeHard)
    else $error("hard fault in nmi or hard handler did not lock");
  AST_LOCK_HOLD: assert property (lockedUp && !debugHalt && !(nmiEvent && !lockedFromNmi) |=> lockedUp)
    else $error("lockup left without release cause");
  AST_NMI_STAYS: assert property (sLockedNmi ##0 sNmiOnly |=> lockedUp)
    else $error("nmi released lockup entered from nmi");
  AST_NO_TAKE: assert property ($past(lockedUp) |-> takeClass == 3'h0 && !takeHard)
    else $error("handler taken while locked");
  AST_BUS_ENTRY: assert property (busPushErr && busHandlerEntry && freeRun |=> takeClass[1])
    else $error("bus push error on bus handler entry not taken by bus handler");
  AST_DIV_TAKE: assert property (zeroDivisor && freeRun |=> takeClass[2] || takeHard)
    else $error("divide by zero raised no fault");
  AST_PRECISE_TAKE: assert property (preciseDataErr && freeRun |=> takeClass[1] || takeHard)
    else $error("precise data error raised no fault");
  AST_RET_GOOD: assert property (retCodeLoad && retCode == FCEL_RET_THREAD_PROC |=> retCodeValid && retTarget == 2'h2)
    else $error("valid return code not accepted");
  AST_RET_BAD: assert property (retCodeLoad && retCode[1:0] != 2'h1 |=> !retCodeValid)
    else $error("reserved return code accepted");
endmodule : fcel_fault_props

bind fcel_fault_unit fcel_fault_props fcel_fault_props_inst (.*);

// ==== tb/tb.sv ====
/*
  Self-checking bench for the fault unit: APB tasks and fault sequences.
  Assumes the core model drives all fault events; bench drives APB and context.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errTotal++; \
  $display("Error %s: expected %h, seen %h", nm, e, g); end end
module tb;
  import fcel_pkg::*;
  logic mclk = 1'b0;
  logic nrst, psel, penable, pwrite, pready, pslverr, inHandler, busHandlerEntry, nmiEvent, debugHalt;
  logic takeHard, lockedUp, lockedFromNmi, retCodeValid, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, busfault_addr_reg, retCode, rdData, a;
  logic [16:0] ev;
  logic [FCEL_PRIO_W-1:0] curPriority;
  fcel_ctx_t curContext;
  logic [2:0] takeClass;
  logic [2:0] expCls;
  logic [1:0] retTarget;
  int errTotal = 0;
  int checked = 0;
  int i;
  logic [11:0] regOf [17] = '{FCEL_OFF_HARD, FCEL_OFF_MM, FCEL_OFF_MM, FCEL_OFF_MM, FCEL_OFF_MM, FCEL_OFF_MM,
    FCEL_OFF_BUS, FCEL_OFF_BUS, FCEL_OFF_BUS, FCEL_OFF_BUS, FCEL_OFF_BUS, FCEL_OFF_USAGE, FCEL_OFF_USAGE,
    FCEL_OFF_USAGE, FCEL_OFF_USAGE, FCEL_OFF_USAGE, FCEL_OFF_USAGE};
  int bitOf [17] = '{FCEL_HF_VECTOR, FCEL_MM_INSTR, FCEL_MM_INSTR, FCEL_MM_DATA, FCEL_MM_PUSH, FCEL_MM_POP,
    FCEL_BF_PUSH, FCEL_BF_POP, FCEL_BF_PREFETCH, FCEL_BF_PRECISE, FCEL_BF_DEFER, FCEL_UF_COPRO,
    FCEL_UF_OPCODE, FCEL_UF_STATE, FCEL_UF_ALIGN, FCEL_UF_DIVZERO, FCEL_UF_RETCODE};
  logic [31:0] rets [3] = '{FCEL_RET_HANDLER_MAIN, FCEL_RET_THREAD_MAIN, FCEL_RET_THREAD_PROC};

  always #4 mclk = ~mclk;

  fcel_fault_unit fcel_fault_unit_inst (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vectorReadErr(ev[0]), .instrAccessViol(ev[1]), .noExecuteHit(ev[2]), .dataAccessViol(ev[3]),
    .protectPushErr(ev[4]), .protectPopErr(ev[5]), .busPushErr(ev[6]), .busPopErr(ev[7]),
    .prefetchBusErr(ev[8]), .preciseDataErr(ev[9]), .deferredDataErr(ev[10]), .coproAccess(ev[11]),
    .illegalOpcode(ev[12]), .badState(ev[13]), .misalignedAccess(ev[14]), .zeroDivisor(ev[15]),
    .retCodeLoad(ev[16]), .retCode(retCode), .busfault_addr_reg(busfault_addr_reg), .curPriority(curPriority),
    .inHandler(inHandler), .busHandlerEntry(busHandlerEntry), .curContext(curContext),
    .nmiEvent(nmiEvent), .debugHalt(debugHalt), .takeClass(takeClass), .takeHard(takeHard),
    .lockedUp(lockedUp), .lockedFromNmi(lockedFromNmi), .retCodeValid(retCodeValid), .retTarget(retTarget)
  );
  fcel_core_model fcel_core_model_inst (.mclk(mclk), .ev(ev), .busfault_addr_reg(busfault_addr_reg), .retCode(retCode));

  // ==========================================================
  // Closing report
  task automatic reportAndStop;
    $display("Comparisons %0d, errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : reportAndStop

  // ==========================================================
  // APB master; bounded wait for pready
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      errTotal++;
      reportAndStop();
    end
    rdData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    `CHK($sformatf("reg %h", ad), e, rdData)
  endtask : rd

  task automatic kick(input logic n, input logic h);
    @(posedge mclk);
    nmiEvent <= n;
    debugHalt <= h;
    @(posedge mclk);
    nmiEvent <= 1'b0;
    debugHalt <= 1'b0;
    #1;
  endtask : kick

  // ==========================================================
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, inHandler, busHandlerEntry, nmiEvent, debugHalt} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    curPriority = 8'h00;
    curContext = FCEL_CTX_OTHER;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    rd(FCEL_OFF_ENABLE, 32'h0);
    apb(1'b0, 12'h024, 32'h0);
    `CHK("unmapped error", 1'b1, lastErr)
    apb(1'b1, FCEL_OFF_ENABLE, 32'h7);
    // Every cause once, then clear
    for (i = 0; i < 17; i++) begin
      a = (i == 16) ? 32'hFFFFFFF2 : {24'hA5C3E0, i[7:0]};
      fcel_core_model_inst.fire(i, a);
      #1;
      expCls = {regOf[i] == FCEL_OFF_USAGE, regOf[i] == FCEL_OFF_BUS, regOf[i] == FCEL_OFF_MM};
      `CHK("take class", expCls, takeClass)
      `CHK("take hard", i == 0, takeHard)
      rd(regOf[i], 32'h1 << bitOf[i]);
      if (i inside {[1:9]}) rd(regOf[i] == FCEL_OFF_MM ? FCEL_OFF_MEMMANAGE_ADDR_REG : FCEL_OFF_BUSADDR, a);
      apb(1'b1, regOf[i], 32'hFFFFFFFF);
      rd(regOf[i], 32'h0);
    end
    fcel_core_model_inst.fire(9, 32'h0);
    fcel_core_model_inst.fire(10, 32'h0);
    rd(FCEL_OFF_BUS, (32'h1 << FCEL_BF_PRECISE) | (32'h1 << FCEL_BF_DEFER));
    apb(1'b1, FCEL_OFF_BUS, 32'hFFFFFFFF);
    // Bus handler disabled
    apb(1'b1, FCEL_OFF_ENABLE, 32'h5);
    fcel_core_model_inst.fire(9, 32'h0);
    rd(FCEL_OFF_HARD, 32'h1 << FCEL_HF_ESCAL);
    apb(1'b1, FCEL_OFF_HARD, 32'hFFFFFFFF);
    @(posedge mclk) busHandlerEntry <= 1'b1;
    fcel_core_model_inst.fire(6, 32'h0);
    rd(FCEL_OFF_HARD, 32'h0);
    @(posedge mclk) busHandlerEntry <= 1'b0;
    apb(1'b1, FCEL_OFF_BUS, 32'hFFFFFFFF);
    apb(1'b1, FCEL_OFF_ENABLE, 32'h7);
    apb(1'b1, FCEL_OFF_PRIO, 32'h00200000);
    rd(FCEL_OFF_PRIO, 32'h00200000);
    // Usage fault in a handler at equal, then lower running priority
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      inHandler <= 1'b1;
      curPriority <= 8'h20 + i[7:0];
      fcel_core_model_inst.fire(15, 32'h0);
      rd(FCEL_OFF_HARD, i == 0 ? 32'h1 << FCEL_HF_ESCAL : 32'h0);
      apb(1'b1, FCEL_OFF_HARD, 32'hFFFFFFFF);
      apb(1'b1, FCEL_OFF_USAGE, 32'hFFFFFFFF);
    end
    @(posedge mclk) inHandler <= 1'b0;
    for (i = 0; i < 3; i++) begin
      fcel_core_model_inst.fire(16, rets[i]);
      #1;
      `CHK("ret valid", 1'b1, retCodeValid)
      `CHK("ret target", i[1:0], retTarget)
    end
    rd(FCEL_OFF_USAGE, 32'h0);
    // Lockup from hard handler, released by nmi
    @(posedge mclk) curContext <= FCEL_CTX_HARD;
    fcel_core_model_inst.fire(0, 32'h0);
    #1;
    `CHK("locked", 1'b1, lockedUp)
    kick(1'b1, 1'b0);
    `CHK("nmi release", 1'b0, lockedUp)
    @(posedge mclk) curContext <= FCEL_CTX_NMI;
    fcel_core_model_inst.fire(0, 32'h0);
    rd(FCEL_OFF_STATE, 32'h3);
    kick(1'b1, 1'b0);
    `CHK("nmi ignored", 1'b1, lockedUp)
    kick(1'b0, 1'b1);
    `CHK("halt release", 1'b0, lockedUp)
    // Reset is the third way out of lockup
    fcel_core_model_inst.fire(0, 32'h0);
    #1;
    `CHK("relocked", 1'b1, lockedUp)
    rd(FCEL_OFF_HARD, 32'h1 << FCEL_HF_VECTOR);
    @(posedge mclk) nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(FCEL_OFF_STATE, 32'h0);
    rd(FCEL_OFF_HARD, 32'h0);
    rd(FCEL_OFF_ENABLE, 32'h0);
    reportAndStop();
  end
endmodule : tb

// ==== verilog/fcel_fault_unit.sv ====
/*
  Fault classification, escalation and lockup unit with an APB register port.
  Assumes single-cycle fault event pulses from pipeline, bus interface and
  protection unit, all on mclk; the prioritiser consumes the take outputs.
*/
// What this block does
// - Vector read bus error raises hard fault
// - Escalation takes hard fault, sets escalation flag
// - Fetch violation or no-execute sets instruction flag
// - Data access violation sets data flag
// - Protection push/pop errors set separate flags
// - Bus push/pop errors set separate flags
// - Prefetch bus error sets prefetch flag
// - Precise and deferred data errors distinct
// - Coprocessor and illegal opcode usage faults
// - Bad instruction state sets state flag
// - Return code, misalign, divide-by-zero flags
// - Only three return codes are valid
// - Configurable priorities and per-class enables
// - Handler re-fault of equal priority escalates
// - Fault not above current priority escalates in a handler
// - Disabled handler escalates to hard fault
// - Bus push fault entering bus handler never escalates
// - Hard fault preempted only by reset/NMI
// - Capture faulting address for bus/protection
// - Hard fault in NMI/hard handler locks
// - Lockup held until reset, NMI, halt
// - NMI cannot release lockup entered from NMI
`timescale 1ns/1ps
module fcel_fault_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault events, one-cycle pulses
  input wire logic vectorReadErr,
  input wire logic instrAccessViol,
  input wire logic noExecuteHit,
  input wire logic dataAccessViol,
  input wire logic protectPushErr,
  input wire logic protectPopErr,
  input wire logic busPushErr,
  input wire logic busPopErr,
  input wire logic prefetchBusErr,
  input wire logic preciseDataErr,
  input wire logic deferredDataErr,
  input wire logic coproAccess,
  input wire logic illegalOpcode,
  input wire logic badState,
  input wire logic retCodeLoad,
  input wire logic [31:0] retCode,
  input wire logic misalignedAccess,
  input wire logic zeroDivisor,
  input wire logic [31:0] busfault_addr_reg,
  // Core context
  input wire logic [fcel_pkg::FCEL_PRIO_W-1:0] curPriority,
  input wire logic inHandler,
  input wire logic busHandlerEntry,
  input wire fcel_pkg::fcel_ctx_t curContext,
  input wire logic nmiEvent,
  input wire logic debugHalt,
  // Toward the prioritiser
  output logic [2:0] takeClass,
  output logic takeHard,
  output logic lockedUp,
  output logic lockedFromNmi,
  output logic retCodeValid,
  output logic [1:0] retTarget
);
  import fcel_pkg::*;

  // ==========================================================
  // Return code check
  logic codeValid;
  logic [1:0] codeTarget;

  fcel_retcode_check uRet (
    .retCode(retCode),
    .codeValid(codeValid),
    .codeTarget(codeTarget)
  );

  // unknown code is a usage fault
  wire badRetCode = retCodeLoad & ~codeValid;

  // ==========================================================
  // State
  logic [31:0] hardCause_r;
  logic [31:0] mmCause_r;
  logic [31:0] busCause_r;
  logic [31:0] usageCause_r;
  logic [31:0] memmanage_addr_reg_r;
  logic [31:0] busAddr_r;
  logic [FCEL_PRIO_W-1:0] prio_r [FCEL_NCLASS];
  logic [FCEL_NCLASS-1:0] enable_r;
  logic [2:0] take_r;
  logic takeHard_r;
  logic locked_r;
  logic lockedNmi_r;
  logic retValid_r;
  logic [1:0] retTarget_r;

  // ==========================================================
  // Classification
  // no-execute counts even with protection off
  wire mmInstr = instrAccessViol | noExecuteHit;
  wire [FCEL_NCLASS-1:0] rawClass;
  assign rawClass[FCEL_CLS_MM] = mmInstr | dataAccessViol | protectPushErr | protectPopErr;
  assign rawClass[FCEL_CLS_BUS] = busPushErr | busPopErr | prefetchBusErr | preciseDataErr | deferredDataErr;
  assign rawClass[FCEL_CLS_USAGE] = coproAccess | illegalOpcode | badState | badRetCode | misalignedAccess
                                    | zeroDivisor;

  // ==========================================================
  // Escalation per class
  wire [FCEL_NCLASS-1:0] escalate;
  wire [FCEL_NCLASS-1:0] taken;

  // fixed-priority handler context
  // Priority field cannot express those levels
  wire fixedCtx = (curContext != FCEL_CTX_OTHER);
  genvar gi;
  generate
    for (gi = 0; gi < FCEL_NCLASS; gi++) begin : gClass
      wire notAbove = fixedCtx | (inHandler & (prio_r[gi] >= curPriority));
      wire disabled = ~enable_r[gi];
      // push fault on bus handler entry exempt
      wire exempt = (gi == FCEL_CLS_BUS) & busHandlerEntry & busPushErr;
      assign escalate[gi] = rawClass[gi] & (notAbove | disabled) & ~exempt;
      assign taken[gi] = rawClass[gi] & ~escalate[gi];
    end
  endgenerate

  wire anyEscalate = |escalate;
  // vector read error goes straight to hard
  wire hardFault = anyEscalate | vectorReadErr;
  // hard fault inside NMI or hard handler
  wire enterLock = hardFault & (curContext != FCEL_CTX_OTHER);
  // release sources
  // Reset is the third path, through nrst
  wire nmiRelease = nmiEvent & ~lockedNmi_r;
  wire lockRelease = debugHalt | nmiRelease;

  // ==========================================================
  // APB decode
  wire apbAccess = psel & penable;
  wire apbWrite = apbAccess & pwrite;
  wire hitHard = (paddr == FCEL_OFF_HARD);
  wire hitMm = (paddr == FCEL_OFF_MM);
  wire hitBus = (paddr == FCEL_OFF_BUS);
  wire hitUsage = (paddr == FCEL_OFF_USAGE);
  wire hitMmAddr = (paddr == FCEL_OFF_MEMMANAGE_ADDR_REG);
  wire hitBusAddr = (paddr == FCEL_OFF_BUSADDR);
  wire hitPrio = (paddr == FCEL_OFF_PRIO);
  wire hitEnable = (paddr == FCEL_OFF_ENABLE);
  wire hitState = (paddr == FCEL_OFF_STATE);
  wire mapped = hitHard | hitMm | hitBus | hitUsage | hitMmAddr | hitBusAddr | hitPrio | hitEnable | hitState;

  // Write-one-to-clear masks
  wire [31:0] clrHard = (apbWrite & hitHard) ? pwdata : 32'h0;
  wire [31:0] clrMm = (apbWrite & hitMm) ? pwdata : 32'h0;
  wire [31:0] clrBus = (apbWrite & hitBus) ? pwdata : 32'h0;
  wire [31:0] clrUsage = (apbWrite & hitUsage) ? pwdata : 32'h0;

  // ==========================================================
  // Cause flag sets
  logic [31:0] setHard;
  logic [31:0] setMm;
  logic [31:0] setBus;
  logic [31:0] setUsage;

  always_comb begin
    setHard = 32'h0;
    setMm = 32'h0;
    setBus = 32'h0;
    setUsage = 32'h0;
    setHard[FCEL_HF_VECTOR] = vectorReadErr;
    setHard[FCEL_HF_ESCAL] = anyEscalate;
    setMm[FCEL_MM_INSTR] = mmInstr;
    setMm[FCEL_MM_DATA] = dataAccessViol;
    setMm[FCEL_MM_PUSH] = protectPushErr;
    setMm[FCEL_MM_POP] = protectPopErr;
    setBus[FCEL_BF_PUSH] = busPushErr;
    setBus[FCEL_BF_POP] = busPopErr;
    setBus[FCEL_BF_PREFETCH] = prefetchBusErr;
    setBus[FCEL_BF_PRECISE] = preciseDataErr;
    setBus[FCEL_BF_DEFER] = deferredDataErr;
    setUsage[FCEL_UF_COPRO] = coproAccess;
    setUsage[FCEL_UF_OPCODE] = illegalOpcode;
    setUsage[FCEL_UF_STATE] = badState;
    setUsage[FCEL_UF_RETCODE] = badRetCode;
    setUsage[FCEL_UF_ALIGN] = misalignedAccess;
    setUsage[FCEL_UF_DIVZERO] = zeroDivisor;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hardCause_r <= 32'h0;
      mmCause_r <= 32'h0;
      busCause_r <= 32'h0;
      usageCause_r <= 32'h0;
    end else begin
      hardCause_r <= (hardCause_r & ~clrHard) | setHard;
      mmCause_r <= (mmCause_r & ~clrMm) | setMm;
      busCause_r <= (busCause_r & ~clrBus) | setBus;
      usageCause_r <= (usageCause_r & ~clrUsage) | setUsage;
    end
  end

  // ==========================================================
  // Fault address capture
  // latch faulting address
  wire mmAddrCap = mmInstr | dataAccessViol | protectPushErr | protectPopErr;
  // Deferred errors carry no usable address
  wire busAddrCap = preciseDataErr | prefetchBusErr | busPushErr | busPopErr;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      memmanage_addr_reg_r <= 32'h0;
      busAddr_r <= 32'h0;
    end else begin
      if (mmAddrCap) begin
        memmanage_addr_reg_r <= busfault_addr_reg;
      end
      if (busAddrCap) begin
        busAddr_r <= busfault_addr_reg;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  // priority and enable per class
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      enable_r <= '0;
      for (int i = 0; i < FCEL_NCLASS; i++) begin
        prio_r[i] <= FCEL_PRIO_W'(FCEL_PRIO_RST);
      end
    end else if (apbWrite) begin
      if (hitEnable) begin
        enable_r <= pwdata[FCEL_NCLASS-1:0];
      end
      if (hitPrio) begin
        for (int i = 0; i < FCEL_NCLASS; i++) begin
          prio_r[i] <= pwdata[i*FCEL_PRIO_W +: FCEL_PRIO_W];
        end
      end
    end
  end

  // ==========================================================
  // Outcome and lockup
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      take_r <= 3'h0;
      takeHard_r <= 1'b0;
      locked_r <= 1'b0;
      lockedNmi_r <= 1'b0;
      retValid_r <= 1'b0;
      retTarget_r <= 2'h0;
    end else begin
      // no class handler dispatch while locked
      take_r <= locked_r ? 3'h0 : taken;
      // lockup replaces the hard fault pulse
      takeHard_r <= hardFault & ~enterLock & ~locked_r;
      retValid_r <= retCodeLoad & codeValid;
      retTarget_r <= codeTarget;
      if (!locked_r && enterLock) begin
        locked_r <= 1'b1;
        lockedNmi_r <= (curContext == FCEL_CTX_NMI);
      end else if (locked_r && lockRelease) begin
        locked_r <= 1'b0;
        lockedNmi_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // APB read path, zero wait states
  wire [31:0] prioWord = {8'h0, prio_r[2], prio_r[1], prio_r[0]};
  wire [31:0] enableWord = {{(32 - FCEL_NCLASS){1'b0}}, enable_r};
  wire [31:0] stateWord = {30'h0, lockedNmi_r, locked_r};

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (hitHard) begin
      rdMux = hardCause_r;
    end else if (hitMm) begin
      rdMux = mmCause_r;
    end else if (hitBus) begin
      rdMux = busCause_r;
    end else if (hitUsage) begin
      rdMux = usageCause_r;
    end else if (hitMmAddr) begin
      rdMux = memmanage_addr_reg_r;
    end else if (hitBusAddr) begin
      rdMux = busAddr_r;
    end else if (hitPrio) begin
      rdMux = prioWord;
    end else if (hitEnable) begin
      rdMux = enableWord;
    end else if (hitState) begin
      rdMux = stateWord;
    end
  end

  assign prdata = rdMux;
  // Decode is combinational, so no wait states
  assign pready = 1'b1;
  // Unmapped access answers with an error
  assign pslverr = apbAccess & ~mapped;

  assign takeClass = take_r;
  assign takeHard = takeHard_r;
  assign lockedUp = locked_r;
  assign lockedFromNmi = lockedNmi_r;
  assign retCodeValid = retValid_r;
  assign retTarget = retTarget_r;
endmodule : fcel_fault_unit

// ==== verilog/fcel_pkg.sv ====
/*
  Constants for the fault classification, escalation and lockup unit:
  register offsets, cause flag positions, return codes, priority widths.
  Assumes a single 125 MHz core clock and an APB register port.
*/
package fcel_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] FCEL_OFF_HARD = 12'h000;
  localparam logic [11:0] FCEL_OFF_MM = 12'h004;
  localparam logic [11:0] FCEL_OFF_BUS = 12'h008;
  localparam logic [11:0] FCEL_OFF_USAGE = 12'h00C;
  localparam logic [11:0] FCEL_OFF_MEMMANAGE_ADDR_REG = 12'h010;
  localparam logic [11:0] FCEL_OFF_BUSADDR = 12'h014;
  localparam logic [11:0] FCEL_OFF_PRIO = 12'h018;
  localparam logic [11:0] FCEL_OFF_ENABLE = 12'h01C;
  localparam logic [11:0] FCEL_OFF_STATE = 12'h020;

  // ==========================================================
  // Fault classes
  localparam int FCEL_NCLASS = 3;
  localparam int FCEL_CLS_MM = 0;
  localparam int FCEL_CLS_BUS = 1;
  localparam int FCEL_CLS_USAGE = 2;
  localparam int FCEL_PRIO_W = 8;
  localparam int FCEL_PRIO_RST = 0;

  // ==========================================================
  // Cause flag positions
  localparam int FCEL_HF_VECTOR = 1;
  localparam int FCEL_HF_ESCAL = 30;
  localparam int FCEL_MM_INSTR = 0;
  localparam int FCEL_MM_DATA = 1;
  localparam int FCEL_MM_POP = 3;
  localparam int FCEL_MM_PUSH = 4;
  localparam int FCEL_BF_PREFETCH = 0;
  localparam int FCEL_BF_PRECISE = 1;
  localparam int FCEL_BF_DEFER = 2;
  localparam int FCEL_BF_POP = 3;
  localparam int FCEL_BF_PUSH = 4;
  localparam int FCEL_UF_OPCODE = 0;
  localparam int FCEL_UF_STATE = 1;
  localparam int FCEL_UF_RETCODE = 2;
  localparam int FCEL_UF_COPRO = 3;
  localparam int FCEL_UF_ALIGN = 8;
  localparam int FCEL_UF_DIVZERO = 9;

  // ==========================================================
  // Handler return codes
  localparam logic [31:0] FCEL_RET_HANDLER_MAIN = 32'hFFFFFFF1;
  localparam logic [31:0] FCEL_RET_THREAD_MAIN = 32'hFFFFFFF9;
  localparam logic [31:0] FCEL_RET_THREAD_PROC = 32'hFFFFFFFD;

  // ==========================================================
  // Execution context of the running handler
  typedef enum logic [1:0] {
    FCEL_CTX_OTHER = 2'h0,
    FCEL_CTX_NMI = 2'h1,
    FCEL_CTX_HARD = 2'h2
  } fcel_ctx_t;
endpackage : fcel_pkg

// ==== verilog/fcel_retcode_check.sv ====
/*
  Checks a handler return code and names its return target.
  Assumes a code that has already been loaded into the program counter.
*/
`timescale 1ns/1ps
module fcel_retcode_check (
  // Code under test
  input wire logic [31:0] retCode,
  // Verdict
  output logic codeValid,
  output logic [1:0] codeTarget
);
  import fcel_pkg::*;

  wire isHandlerMain = (retCode == FCEL_RET_HANDLER_MAIN);
  wire isThreadMain = (retCode == FCEL_RET_THREAD_MAIN);
  wire isThreadProc = (retCode == FCEL_RET_THREAD_PROC);

  assign codeValid = isHandlerMain | isThreadMain | isThreadProc;
  assign codeTarget = isThreadProc ? 2'h2 : (isThreadMain ? 2'h1 : 2'h0);
endmodule : fcel_retcode_check
